// file: verilog/fdc_xfer_params.svh
/*
 floppy data-command engine constants: register offsets, field positions,
 a completion code, the first sector number and timing counts. assumes a 10 MHz clk_sys and an APB master.
*/
`ifndef FDC_XFER_PARAMS_SVH
`define FDC_XFER_PARAMS_SVH
`define REG_CMD 8'h00
`define REG_IDW 8'h04
`define REG_PARAM 8'h08
`define REG_SPT 8'h0c
`define REG_STATUS 8'h10
`define REG_RESULT 8'h14
`define REG_WDATA 8'h18
`define REG_RDATA 8'h1c
`define CMD_GO_BIT 7
`define CMD_MT_BIT 6
`define CMD_OMIT_BIT 5
`define CMD_EC_BIT 4
`define ST0_IC_ABN 2'b01
`define SEC_FIRST 8'h01
`define HEAD_LOAD_US 16
`define HEAD_LOAD_CYC ((`HEAD_LOAD_US * 10 + 0) < 1 ? 1 : (`HEAD_LOAD_US * 10))
`endif

// file: verilog/fdc_xfer_pkg.sv
/*
 floppy data-command engine types. assumes fdc_xfer_params.svh for numbers.
*/
package fdc_xfer_pkg;
   typedef enum logic [2:0] {
      op_read_del = 3'b000,
      op_read_trk = 3'b001,
      op_write = 3'b010,
      op_write_del = 3'b011,
      op_verify = 3'b100,
      op_format = 3'b101
   } op_e;
   typedef enum logic [3:0] {
      st_idle = 4'b0000,
      st_load = 4'b0001,
      st_wait_idx = 4'b0010,
      st_find_id = 4'b0011,
      st_data = 4'b0100,
      st_wr_data = 4'b0101,
      st_fmt = 4'b0110,
      st_result = 4'b0111
   } state_e;
   typedef struct packed {
      logic [7:0] cyl;
      logic [7:0] head;
      logic [7:0] sec;
      logic [7:0] size;
   } chrn_s;
   // events reported by the drive-side data separator
   typedef struct packed {
      logic index;
      logic id_found;
      logic id_crc_err;
      logic dam_found;
      logic dam_deleted;
      logic data_byte;
      logic data_end;
      logic data_crc_err;
   } media_s;
   typedef struct packed {
      logic [1:0] completion_code;
      logic absent_id_flag;
      logic no_data_flag;
      logic data_crc_error;
      logic control_mark_flag;
      logic invalid;
   } status_s;
endpackage

// file: verilog/fdc_xfer_engine.sv
/*
 data-transfer command engine of a floppy controller, with an apb register
 slave. assumes a separator that flags ids, marks and bytes in clk_sys, and
 a drive that accepts write bytes one per wr_byte_ready pulse.
*/
// Chosen here: the APB register port and the register addresses.
`timescale 1ns/1ns
`include "fdc_xfer_params.svh"
module fdc_xfer_engine
   import fdc_xfer_pkg::*;
(
   input wire logic clk_sys, // 10 mhz clock
   input wire logic resetn, // sync reset, active low
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb byte address
   input wire logic [31:0] pwdata, // apb write data
   output logic [31:0] prdata, // apb read data
   output logic pready, // apb ready
   output logic pslverr, // apb error, unmapped
   input wire logic index_input_pin, // index pulse pin, async
   input wire logic terminal_count, // host terminal count, async pin
   input wire media_s media, // separator events, same clock
   input wire chrn_s media_id, // id field just read
   input wire logic [7:0] media_byte, // data byte read
   input wire logic wr_byte_ready, // drive takes one write byte
   output logic write_gate, // drive write enable
   output logic [7:0] wr_byte, // byte to drive
   output logic wr_mark, // current byte is a mark
   output logic wr_mark_deleted, // mark kind is deleted
   output logic head_load // head load request
);
   typedef struct packed {
      state_e state;
      op_e op;
      logic mt;
      logic omit;
      logic ec;
      chrn_s id;
      logic [7:0] last_track_record;
      logic [7:0] count;
      logic [7:0] fill;
      logic [7:0] spt;
      logic [15:0] timer;
      logic [13:0] bytes;
      logic [1:0] idx_seen;
      logic loaded;
      logic stop;
      logic last;
      logic skip;
      status_s st;
      logic [7:0] wbuf;
      logic wfull;
      logic [7:0] rbuf;
      logic rfull;
      logic wr_gate;
      logic [7:0] wr_out;
      logic mk;
      logic mk_del;
      logic [31:0] rdata;
      logic [1:0] idx_sy;
      logic [1:0] tc_sy;
      logic idx_prev;
      logic ph;
   } regs_s;
   regs_s r;
   regs_s next_r;
   logic idx_edge;
   logic tc_lvl;
   logic acc;
   logic xfer;
   logic [13:0] sec_len;
   chrn_s adv;
   assign idx_edge = r.idx_sy[1] & ~r.idx_prev;
   assign tc_lvl = r.tc_sy[1];
   assign acc = psel & penable;
   // one wait state: read data is registered in the first access cycle
   assign xfer = acc & r.ph;
   assign sec_len = 14'h0080 << r.id.size[2:0];
   // result id update for a completed sector
   always_comb begin
      adv = r.id;
      if (r.id.sec != r.last_track_record) begin
         adv.sec = r.id.sec + 8'h01;
      end else begin
         adv.sec = `SEC_FIRST;
         if (r.mt) begin
            adv.head = {r.id.head[7:1], ~r.id.head[0]};
            if (r.id.head[0]) begin
               adv.cyl = r.id.cyl + 8'h01;
            end
         end else begin
            adv.cyl = r.id.cyl + 8'h01;
         end
      end
   end
   always_comb begin
      next_r = r;
      next_r.idx_sy = {r.idx_sy[0], index_input_pin};
      next_r.tc_sy = {r.tc_sy[0], terminal_count};
      next_r.idx_prev = r.idx_sy[1];
      next_r.ph = acc & ~r.ph;
      if (tc_lvl && r.state != st_idle) begin
         next_r.stop = 1'b1;
      end
      // apb register access
      next_r.rdata = 32'h0;
      if (xfer && pwrite) begin
         if (paddr == `REG_CMD && r.state == st_idle && pwdata[`CMD_GO_BIT]) begin
            next_r.op = op_e'(pwdata[2:0]);
            next_r.mt = pwdata[`CMD_MT_BIT];
            next_r.omit = pwdata[`CMD_OMIT_BIT];
            next_r.ec = pwdata[`CMD_EC_BIT];
            next_r.st = '0;
            next_r.stop = 1'b0;
            next_r.last = 1'b0;
            next_r.skip = 1'b0;
            next_r.idx_seen = 2'b00;
            next_r.bytes = 14'h0;
            next_r.timer = 16'h0;
            next_r.state = r.loaded ? st_wait_idx : st_load;
         end else if (paddr == `REG_IDW) begin
            next_r.id = pwdata;
         end else if (paddr == `REG_PARAM) begin
            next_r.last_track_record = pwdata[7:0];
            next_r.count = pwdata[15:8];
            next_r.fill = pwdata[23:16];
         end else if (paddr == `REG_SPT) begin
            next_r.spt = pwdata[7:0];
         end else if (paddr == `REG_WDATA && !r.wfull) begin
            next_r.wbuf = pwdata[7:0];
            next_r.wfull = 1'b1;
         end
      end else if (acc && !pwrite) begin
         if (paddr == `REG_STATUS) begin
            next_r.rdata = {16'h0, 4'h0, r.wfull, r.rfull, r.state == st_result,
               r.state != st_idle, 1'b0, r.st};
         end else if (paddr == `REG_RESULT) begin
            next_r.rdata = r.id;
         end else if (paddr == `REG_RDATA) begin
            next_r.rdata = {23'h0, r.rfull, r.rbuf};
            next_r.rfull = r.rfull & ~xfer;
         end else if (paddr == `REG_CMD) begin
            next_r.rdata = {24'h0, 1'b0, r.mt, r.omit, r.ec, 1'b0, r.op};
         end else if (paddr == `REG_PARAM) begin
            next_r.rdata = {8'h0, r.fill, r.count, r.last_track_record};
         end else if (paddr == `REG_SPT) begin
            next_r.rdata = {24'h0, r.spt};
         end
      end
      if (idx_edge && r.idx_seen != 2'b11) begin
         next_r.idx_seen = r.idx_seen + 2'b01;
      end
      case (r.state)
         st_idle: begin
            next_r.wr_gate = 1'b0;
         end
         st_load: begin
            next_r.timer = r.timer + 16'h1;
            if (r.timer == 16'(`HEAD_LOAD_CYC)) begin
               next_r.loaded = 1'b1;
               next_r.state = st_wait_idx;
            end
         end
         st_wait_idx: begin
            next_r.idx_seen = 2'b00;
            if (r.op == op_verify && r.last_track_record > r.spt) begin
               next_r.st.invalid = 1'b1;
               next_r.st.completion_code = `ST0_IC_ABN;
               next_r.state = st_result;
            end else if (r.op == op_read_trk || r.op == op_format) begin
               if (idx_edge) begin
                  next_r.state = r.op == op_format ? st_fmt : st_find_id;
                  next_r.wr_gate = r.op == op_format;
               end
            end else begin
               next_r.state = st_find_id;
            end
         end
         st_find_id: begin
            if (r.idx_seen == 2'b10 && r.op != op_read_trk && r.op != op_format) begin
               next_r.st.completion_code = `ST0_IC_ABN;
               next_r.st.no_data_flag = 1'b1;
               next_r.state = st_result;
            end else if (r.idx_seen == 2'b10 && r.op == op_read_trk) begin
               next_r.state = st_result;
               if (r.bytes == 14'h0) begin
                  next_r.st.completion_code = `ST0_IC_ABN;
                  next_r.st.absent_id_flag = 1'b1;
               end
            end else if (media.id_found) begin
               next_r.idx_seen = r.op == op_read_trk ? r.idx_seen : 2'b00;
               if (media.id_crc_err) begin
                  if (r.op == op_read_trk) begin
                     next_r.st.data_crc_error = 1'b1;
                  end else begin
                     next_r.st.completion_code = `ST0_IC_ABN;
                     next_r.st.data_crc_error = 1'b1;
                     next_r.state = st_result;
                  end
               end else if (r.op == op_read_trk) begin
                  if (media_id != r.id) begin
                     next_r.st.no_data_flag = 1'b1;
                  end
                  next_r.bytes = 14'h1;
                  next_r.state = st_data;
               end else if (media_id == r.id) begin
                  next_r.bytes = 14'h0;
                  if (r.op == op_write || r.op == op_write_del) begin
                     next_r.wr_gate = 1'b1;
                     next_r.mk = 1'b1;
                     next_r.mk_del = r.op == op_write_del;
                     next_r.state = st_wr_data;
                  end else begin
                     next_r.state = st_data;
                  end
               end
            end
         end
         st_data: begin
            if (media.dam_found) begin
               next_r.skip = 1'b0;
               if (r.op == op_read_del && !media.dam_deleted) begin
                  next_r.st.control_mark_flag = 1'b1;
                  next_r.skip = r.omit;
                  next_r.last = ~r.omit;
               end
            end
            // verify moves nothing to the host
            if (media.data_byte && !r.skip && r.op != op_verify && !r.stop) begin
               if (r.rfull) begin
                  next_r.stop = 1'b1; // overrun acts as terminal count
               end else begin
                  next_r.rbuf = media_byte;
                  next_r.rfull = 1'b1;
               end
            end
            if (media.data_end) begin
               if (media.data_crc_err && !r.skip) begin
                  next_r.st.data_crc_error = 1'b1;
                  if (r.op != op_read_trk) begin
                     next_r.st.completion_code = `ST0_IC_ABN;
                     next_r.state = st_result;
                  end
               end
               if (r.op == op_read_trk) begin
                  if (!(media.data_crc_err && 1'b0)) begin
                     next_r.state = st_find_id;
                  end
               end else if (!(media.data_crc_err && !r.skip)) begin
                  if (r.last) begin
                     next_r.state = st_result;
                  end else begin
                     next_r.id = adv;
                     next_r.count = r.count - 8'h01;
                     if (r.op == op_verify && r.ec && r.count == 8'h01) begin
                        next_r.state = st_result;
                     end else if (r.stop || (r.id.sec == r.last_track_record &&
                                  !(r.mt && !r.id.head[0]))) begin
                        next_r.state = st_result;
                     end else begin
                        next_r.state = st_find_id;
                     end
                  end
               end
            end
         end
         st_wr_data: begin
            if (wr_byte_ready) begin
               next_r.mk = 1'b0;
               if (!r.mk) begin
                  next_r.bytes = r.bytes + 14'h1;
                  if (r.wfull && !r.stop) begin
                     next_r.wr_out = r.wbuf;
                     next_r.wfull = 1'b0;
                  end else begin
                     next_r.wr_out = 8'h00;
                     next_r.stop = 1'b1;
                  end
                  if (r.bytes == sec_len - 14'h1) begin
                     next_r.wr_gate = 1'b0; // drive appends crc
                     next_r.id = adv;
                     next_r.state = (r.stop || r.id.sec == r.last_track_record) ? st_result : st_find_id;
                  end
               end
            end
         end
         st_fmt: begin
            if (idx_edge) begin
               next_r.wr_gate = 1'b0;
               next_r.state = st_result;
            end else if (wr_byte_ready) begin
               next_r.wr_gate = 1'b1;
               next_r.bytes = r.bytes + 14'h1;
               next_r.mk = r.bytes == 14'h0;
               next_r.mk_del = 1'b0;
               if (r.bytes < 14'h4) begin
                  next_r.wr_out = r.id[31 - 8 * r.bytes[1:0] -: 8];
               end else begin
                  next_r.wr_out = r.fill;
               end
               if (r.bytes == sec_len + 14'h3) begin
                  next_r.bytes = 14'h0;
               end
            end
         end
         st_result: begin
            next_r.wr_gate = 1'b0;
            if (xfer && !pwrite && paddr == `REG_RESULT) begin
               next_r.state = st_idle;
            end
         end
         default: next_r.state = st_idle;
      endcase
      if (!resetn) begin
         next_r = '0;
         next_r.state = st_idle;
      end
   end
   always_ff @(posedge clk_sys) begin
      r <= next_r;
   end
   assign prdata = r.rdata;
   assign pready = xfer;
   assign pslverr = xfer && !(paddr == `REG_CMD || paddr == `REG_IDW ||
      paddr == `REG_PARAM || paddr == `REG_SPT || paddr == `REG_STATUS ||
      paddr == `REG_RESULT || paddr == `REG_WDATA || paddr == `REG_RDATA);
   assign write_gate = r.wr_gate;
   assign wr_byte = r.wr_out;
   assign wr_mark = r.mk;
   assign wr_mark_deleted = r.mk_del;
   assign head_load = r.loaded | (r.state == st_load);
endmodule

// file: bench/fdc_xfer_sva.sv
/* concurrent checks on the data-command engine ports.
   assumes a bind onto fdc_xfer_engine, one clk_sys domain. */
`timescale 1ns/1ns
module fdc_xfer_sva
   import fdc_xfer_pkg::*;
(
   input wire logic clk_sys, // clock
   input wire logic resetn, // sync reset
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic [7:0] paddr, // apb address
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic terminal_count, // host terminal count
   input wire logic wr_byte_ready, // drive takes byte
   input wire logic write_gate, // write enable
   input wire logic [7:0] wr_byte, // write byte
   input wire logic wr_mark, // mark byte
   input wire logic head_load // head load
);
   logic [7:0] load_cnt;
   default clocking dc @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   // cycles the head has stayed loaded, saturating
   always_ff @(posedge clk_sys) begin
      if (!resetn || !head_load) begin
         load_cnt <= 8'h00;
      end else if (load_cnt != 8'hff) begin
         load_cnt <= load_cnt + 8'h01;
      end
   end
   a_ready_access: assert property (pready |-> psel && penable)
      else $error("pready outside access");
   a_ready_wait: assert property (psel && penable && !pready |=> pready)
      else $error("more than one wait state");
   a_err_unmapped: assert property (pready && paddr > 8'h1c |-> pslverr)
      else $error("unmapped access not flagged");
   a_err_mapped: assert property (psel && penable && paddr <= 8'h1c |-> !pslverr)
      else $error("mapped access flagged");
   a_err_access: assert property (pslverr |-> psel && penable)
      else $error("pslverr outside access");
   a_mark_gated: assert property (wr_mark |-> write_gate)
      else $error("mark without write gate");
   a_gate_head: assert property (write_gate |-> head_load)
      else $error("writing with head unloaded");
   a_head_wait: assert property ($rose(write_gate) |-> load_cnt >= 8'd159)
      else $error("write before head load time");
   a_tc_pad: assert property (terminal_count [*4] ##1
      (terminal_count && wr_byte_ready && !wr_mark) |=> (wr_byte == 8'h00 || wr_mark || !write_gate))
      else $error("field not padded with zeros");
   a_byte_hold: assert property ((write_gate && !wr_byte_ready) ##1 write_gate |-> $stable(wr_byte))
      else $error("write byte changed before taken");
   c_write: cover property ($rose(write_gate));
   c_unmapped: cover property (pslverr);
   c_tc: cover property (terminal_count && write_gate);
endmodule

// file: bench/fdc_media_model.sv
/* behavioural drive and data separator facing the engine.
   assumes the bench calls track and reads the write tallies. */
`timescale 1ns/1ns
module fdc_media_model
   import fdc_xfer_pkg::*;
(
   input wire logic clk_sys, // clock
   input wire logic write_gate, // write enable
   input wire logic [7:0] wr_byte, // byte from engine
   input wire logic wr_mark, // byte is a mark
   input wire logic wr_mark_deleted, // mark is deleted
   output media_s media, // separator events
   output chrn_s media_id, // id field
   output logic [7:0] media_byte, // data byte
   output logic wr_byte_ready, // byte taken
   output logic index_input_pin // index pulse
);
   int marks = 0;
   int del_marks = 0;
   int nonzero = 0;
   initial begin
      media = '0;
      media_id = '0;
      media_byte = 8'h00;
      wr_byte_ready = 1'b0;
      index_input_pin = 1'b0;
   end
   // take a byte every other cycle while the gate is open
   always @(posedge clk_sys) begin
      wr_byte_ready <= write_gate && !wr_byte_ready;
      if (write_gate && wr_byte_ready) begin
         if (wr_mark) begin
            marks++;
            del_marks += int'(wr_mark_deleted);
         end else if (wr_byte != 8'h00) begin
            nonzero++;
         end
      end
   end
   // one-cycle event; id and byte invert afterwards so stale values never look valid
   task automatic ev(input logic [7:0] m, input chrn_s i, input logic [7:0] b);
      @(posedge clk_sys);
      media <= media_s'(m);
      media_id <= i;
      media_byte <= b;
      @(posedge clk_sys);
      media <= '0;
      media_id <= ~i;
      media_byte <= ~b;
   endtask
   // one revolution: index, then n sectors of 128 bytes
   task automatic track(input chrn_s id, input int n, input logic [7:0] del, bad);
      index_input_pin <= 1'b1;
      repeat (4) @(posedge clk_sys);
      index_input_pin <= 1'b0;
      for (int s = 1; s <= n; s++) begin
         repeat (20) @(posedge clk_sys);
         ev(bad[s] ? 8'h60 : 8'h40, {id[31:16], 8'(s), id[7:0]}, media_byte);
         repeat (20) @(posedge clk_sys);
         ev(del[s] ? 8'h18 : 8'h10, media_id, media_byte);
         repeat (128) ev(8'h04, media_id, 8'($urandom));
         ev(8'h02, media_id, media_byte);
      end
      repeat (40) @(posedge clk_sys);
   endtask
endmodule

// file: bench/tb_top.sv
/* self-checking bench for the floppy data-command engine.
   assumes fdc_media_model plays the drive and the bench the host. */
`timescale 1ns/1ns
module tb_top;
   import fdc_xfer_pkg::*;
   logic clk_sys = 1'b0;
   logic resetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, terminal_count = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, st, res;
   logic pready, pslverr, e, write_gate, wr_byte_ready, wr_mark, wr_mark_deleted, head_load;
   logic index_input_pin;
   logic [7:0] wr_byte, media_byte;
   media_s media;
   chrn_s media_id, id;
   int bad_count = 0;
   int tests_run = 0;
   always #50 clk_sys = ~clk_sys;
   fdc_xfer_engine uut (.clk_sys, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .index_input_pin, .terminal_count, .media, .media_id,
      .media_byte, .wr_byte_ready, .write_gate, .wr_byte, .wr_mark, .wr_mark_deleted, .head_load);
   fdc_media_model drv (.clk_sys, .write_gate, .wr_byte, .wr_mark, .wr_mark_deleted, .media,
      .media_id, .media_byte, .wr_byte_ready, .index_input_pin);
   task automatic summarize();
      if (bad_count == 0 && tests_run > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, exp);
      tests_run++;
      if (got !== exp) begin
         bad_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // read data and error are taken at the edge where pready is high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do @(posedge clk_sys); while (pready !== 1'b1);
      e = pslverr;
      rd = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_sys);
   endtask
   function automatic chrn_s next_id(chrn_s i, logic mt, logic [7:0] last);
      next_id = i;
      if (i.sec != last) begin
         next_id.sec = i.sec + 8'h01;
      end else begin
         next_id.sec = 8'h01;
         if (mt) next_id.head[0] = ~i.head[0];
         if (!mt || i.head[0]) next_id.cyl = i.cyl + 8'h01;
      end
   endfunction
   task automatic run(input logic [7:0] cmd, input logic [15:0] cl, input chrn_s tid,
         input int n, revs, input logic [7:0] del, bad);
      int k;
      apb(1'b1, 8'h04, id);
      apb(1'b1, 8'h08, {8'h00, 8'($urandom), cl});
      apb(1'b1, 8'h0c, 32'h4);
      apb(1'b1, 8'h00, {24'h0, cmd});
      // leave room for a head load before the first id passes
      repeat (170) @(posedge clk_sys);
      fork
         repeat (revs) drv.track(tid, n, del, bad);
      join_none
      k = 0;
      do begin
         apb(1'b0, 8'h10, 32'h0);
         k++;
      end while (rd[9] !== 1'b1 && k < 3000);
      chk(32'(k < 3000), 32'h1);
      st = rd;
      wait fork;
      apb(1'b0, 8'h14, 32'h0);
      res = rd;
   endtask
   initial begin
      id = {8'($urandom(15) % 200), 8'h00, 8'h01, 8'h00};
      repeat (4) @(posedge clk_sys);
      resetn <= 1'b1;
      @(posedge clk_sys);
      apb(1'b0, 8'h10, 32'h0);
      chk(rd & 32'hfff, 32'h0);
      apb(1'b0, 8'h20, 32'h0);
      chk({31'h0, e}, 32'h1);
      for (int k = 0; k < 4; k++) begin
         id.head = {7'h0, k[0]};
         run({1'b1, k[1], 6'h00}, {8'hff, (k == 1) ? 8'h03 : 8'h01}, id, 3, 1, 8'hff, 8'h00);
         chk(st & 32'h2, 32'h0);
         chk(res, next_id(id, k[1], (k == 1) ? 8'h03 : 8'h01));
      end
      id.head = 8'h00;
      run(8'h80, 16'hff03, id, 3, 1, 8'h00, 8'h00);
      chk(st & 32'h2, 32'h2);
      chk(res, id);
      run(8'ha0, 16'hff02, id, 3, 1, 8'h04, 8'h00);
      chk(st & 32'h62, 32'h02);
      run(8'h81, 16'hff01, id, 0, 3, 8'h00, 8'h00);
      chk(st & 32'h70, 32'h30);
      run(8'h81, 16'hff02, {id.cyl + 8'h01, id[23:0]}, 3, 3, 8'h00, 8'h02);
      chk(st & 32'h0c, 32'h0c);
      for (int k = 2; k < 4; k++) begin
         drv.marks = 0;
         drv.del_marks = 0;
         drv.nonzero = 0;
         fork
            begin
               wait (write_gate === 1'b1);
               repeat (10) @(posedge clk_sys);
               terminal_count <= 1'b1;
            end
         join_none
         run(8'h80 | 8'(k), 16'hff01, id, 3, 1, 8'h00, 8'h00);
         terminal_count <= 1'b0;
         chk(32'(drv.marks > 0), 32'h1);
         chk(32'(drv.del_marks), (k == 3) ? 32'(drv.marks) : 32'h0);
         chk(32'(drv.nonzero), 32'h0);
      end
      run(8'h82, 16'hff01, id, 3, 1, 8'h00, 8'h02);
      chk(st & 32'h64, 32'h24);
      apb(1'b0, 8'h1c, 32'h0);
      run(8'h84, 16'hff02, id, 3, 1, 8'h00, 8'h00);
      chk(st & 32'h401, 32'h0);
      apb(1'b0, 8'h1c, 32'h0);
      chk(rd & 32'h100, 32'h0);
      run(8'h84, 16'hff05, id, 3, 1, 8'h00, 8'h00);
      chk(st & 32'h1, 32'h1);
      run(8'h94, 16'h0104, id, 3, 1, 8'h00, 8'h00);
      chk(res, next_id(id, 1'b0, 8'h04));
      drv.marks = 0;
      run(8'h85, 16'hff01, id, 0, 2, 8'h00, 8'h00);
      chk(32'(drv.marks > 0), 32'h1);
      chk(st & 32'h7f, 32'h0);
      chk(res, id);
      summarize();
   end
   initial begin
      repeat (90000) @(posedge clk_sys);
      bad_count++;
      summarize();
   end
endmodule
bind fdc_xfer_engine fdc_xfer_sva chk_i (.clk_sys, .resetn, .psel, .penable, .paddr, .pready,
   .pslverr, .terminal_count, .wr_byte_ready, .write_gate, .wr_byte, .wr_mark, .head_load);
